// ==== design/pfr_pkg.sv ====
// constants, register map and state types of the packet framer
// assumes a 100 MHz mclk and an APB master with 12-bit byte addresses
package pfr_pkg;
  localparam int ADDR_W = 12;
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_SYNC_CTRL = 10'h120;
  localparam logic [9:0] IDX_SYNC_UPPER = 10'h121;
  localparam logic [9:0] IDX_SYNC_MIDDLE = 10'h122;
  localparam logic [9:0] IDX_SYNC_LOWER = 10'h123;
  localparam logic [9:0] IDX_TX_BASE = 10'h124;
  localparam logic [9:0] IDX_RX_BASE = 10'h125;
  localparam logic [9:0] IDX_LEN_CTRL = 10'h126;
  localparam logic [9:0] IDX_MAX_LEN = 10'h127;
  localparam logic [9:0] IDX_CMD = 10'h130;
  localparam logic [9:0] IDX_STATUS = 10'h131;
  localparam logic [9:0] IDX_RX_COUNT = 10'h132;
  localparam logic [1:0] RAM_SEL = 2'h0;
  // length control fields
  localparam int LC_ORDER = 7;
  localparam int LC_FIXED = 6;
  localparam int LC_CRC = 5;
  localparam int LC_MODE_HI = 4;
  localparam int LC_MODE_LO = 3;
  localparam int LC_OFF_HI = 2;
  localparam int SC_LEN_HI = 4;
  localparam int CMD_TX_START = 0;
  localparam int CMD_RX_EN = 1;
  localparam int CMD_STREAM = 2;
  localparam int ST_RX_DONE = 2;
  localparam int ST_CRC_ERR = 3;
  localparam int ST_LEN_ERR = 4;
  localparam int ST_IRQ = 5;
  localparam logic [1:0] MODE_PACKET = 2'h0;
  localparam logic [1:0] MODE_SPORT_PRE = 2'h1;
  localparam logic [1:0] MODE_SPORT_SYNC = 2'h2;
  localparam logic [7:0] LEN_BIAS = 8'h04;
  localparam logic [4:0] SYNC_LEN_FULL = 5'h10;
  localparam logic [4:0] SYNC_LEN_MID = 5'h08;
  localparam logic [4:0] SYNC_LEN_MAX = 5'h18;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_SYNC_CTRL = 8'h18;
  // bit timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [6:0] BIT_LAST = 7'(BIT_CYCLES - 1);
  localparam logic [7:0] PREAMBLE_BYTES = 8'h03;
  localparam logic [7:0] PREAMBLE_PATTERN = 8'hAA;
  localparam logic [4:0] PRE_DETECT_BITS = 5'h10;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SYNC, TX_PAY, TX_CRC, TX_STREAM} pfr_tx_e;
  typedef enum logic [2:0] {RX_OFF, RX_HUNT, RX_SYNC, RX_LEN, RX_PAY, RX_CRC, RX_SPORT} pfr_rx_e;
endpackage

// ==== design/pfr_crc.sv ====
// bit-serial CRC-16 register shared by transmit and receive
// assumes one bit per enabled cycle, most significant bit first
module pfr_crc (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic en,
  input wire logic din,
  output logic [15:0] crc_nxt
);
  logic [15:0] crc_ff;
  wire fb = crc_ff[15] ^ din;
  wire [15:0] crc_step = {crc_ff[14:0], 1'b0} ^ (fb ? pfr_pkg::CRC_POLY : 16'h0000);

  // the next value is exposed so a caller sees the remainder including this bit
  assign crc_nxt = clr ? pfr_pkg::CRC_INIT : (en ? crc_step : crc_ff);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      crc_ff <= pfr_pkg::CRC_INIT;
    end else begin
      crc_ff <= crc_nxt;
    end
  end
endmodule

// ==== design/pfr_framer.sv ====
// sync and length framer: APB registers, packet RAM, bit transmitter and receiver
// assumes rx_data_pin and sport_tx_data are asynchronous to mclk
module pfr_framer (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pfr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_data_pin,
  input wire logic sport_tx_data,
  output logic tx_data,
  output logic tx_active,
  output logic sport_rx_data,
  output logic sport_rx_valid,
  output logic general_purpose_interrupt_pin
);
  logic [7:0] pkt_ram [0:255];
  logic [7:0] sync_ctrl_ff, tx_base_ff, rx_base_ff, len_ctrl_ff, max_len_ff, rx_count_ff;
  logic [23:0] pat_ff;
  logic rx_en_ff, stream_ff, done_ff, crc_err_ff, len_err_ff, irq_ff;
  logic [31:0] prdata_ff, rd_mux;
  logic mapped;
  logic rx_meta_ff, rx_sync_ff, stx_meta_ff, stx_sync_ff;
  logic [6:0] tick_cnt_ff;
  logic tick_ff;
  pfr_pkg::pfr_tx_e tx_st_ff, nxt_tx_st;
  logic [15:0] tx_sh_ff, nxt_tx_sh;
  logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [7:0] tx_cnt_ff, nxt_tx_cnt, tx_ptr_ff, nxt_tx_ptr;
  logic [1:0] tx_sidx_ff, nxt_tx_sidx;
  logic go_pay, tx_data_ff, tx_active_ff;
  pfr_pkg::pfr_rx_e rx_st_ff, nxt_rx_st;
  logic [7:0] rx_byte_ff, nxt_rx_byte, rx_cnt_ff, nxt_rx_cnt, rx_ptr_ff, nxt_rx_ptr;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [23:0] rx_sh_ff;
  logic [4:0] pre_cnt_ff;
  logic rx_fin, eng_we, rx_crc_clr, ev_done, ev_crc_err, ev_len_err, ev_irq, ev_len;
  logic sport_data_ff, sport_valid_ff;
  logic [15:0] crc_nxt;

  function automatic logic [7:0] put_order(input logic msb, input logic [7:0] b);
    logic [7:0] r;
    r = b;
    if (!msb) begin
      for (int i = 0; i < 8; i++) r[i] = b[7-i];
    end
    return r;
  endfunction

  // index 0 is the upper byte so the pattern leaves the top bit first
  function automatic logic [7:0] pat_byte(input logic [23:0] p, input logic [1:0] i);
    return (i == 2'h0) ? p[23:16] : ((i == 2'h1) ? p[15:8] : p[7:0]);
  endfunction

  // ---------------- APB slave ----------------
  wire [9:0] idx = paddr[pfr_pkg::ADDR_W-1:2];
  wire ram_hit = idx[9:8] == pfr_pkg::RAM_SEL;
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  // the receiver owns the RAM write port in its byte cycle; the bus waits one cycle
  assign pready = ~(ram_hit & eng_we);
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;

  wire [1:0] mode = len_ctrl_ff[pfr_pkg::LC_MODE_HI:pfr_pkg::LC_MODE_LO];
  wire fixed_length_select = len_ctrl_ff[pfr_pkg::LC_FIXED];
  wire crc_on = len_ctrl_ff[pfr_pkg::LC_CRC];
  wire msb_first = len_ctrl_ff[pfr_pkg::LC_ORDER];
  wire [7:0] len_off = {5'h00, len_ctrl_ff[pfr_pkg::LC_OFF_HI:0]};
  wire [4:0] sync_len = sync_ctrl_ff[pfr_pkg::SC_LEN_HI:0];
  wire tx_idle = tx_st_ff == pfr_pkg::TX_IDLE;
  wire tx_start = wr & (idx == pfr_pkg::IDX_CMD) & pwdata[pfr_pkg::CMD_TX_START] & tx_idle;
  wire st_clr = wr & (idx == pfr_pkg::IDX_STATUS);
  wire [7:0] status = {2'h0, irq_ff, len_err_ff, crc_err_ff, done_ff, rx_st_ff != pfr_pkg::RX_OFF, ~tx_idle};

  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    case (idx)
      pfr_pkg::IDX_SYNC_CTRL: rd_mux[7:0] = sync_ctrl_ff;
      pfr_pkg::IDX_SYNC_UPPER: rd_mux[7:0] = pat_ff[23:16];
      pfr_pkg::IDX_SYNC_MIDDLE: rd_mux[7:0] = pat_ff[15:8];
      pfr_pkg::IDX_SYNC_LOWER: rd_mux[7:0] = pat_ff[7:0];
      pfr_pkg::IDX_TX_BASE: rd_mux[7:0] = tx_base_ff;
      pfr_pkg::IDX_RX_BASE: rd_mux[7:0] = rx_base_ff;
      pfr_pkg::IDX_LEN_CTRL: rd_mux[7:0] = len_ctrl_ff;
      pfr_pkg::IDX_MAX_LEN: rd_mux[7:0] = max_len_ff;
      pfr_pkg::IDX_CMD: rd_mux[2:0] = {stream_ff, rx_en_ff, 1'b0};
      pfr_pkg::IDX_STATUS: rd_mux[7:0] = status;
      pfr_pkg::IDX_RX_COUNT: rd_mux[7:0] = rx_count_ff;
      default: begin
        mapped = ram_hit;
        rd_mux[7:0] = ram_hit ? pkt_ram[idx[7:0]] : 8'h00;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_ctrl_ff <= pfr_pkg::RST_SYNC_CTRL;
      pat_ff <= {3{pfr_pkg::RST_BYTE}};
      tx_base_ff <= pfr_pkg::RST_BYTE;
      rx_base_ff <= pfr_pkg::RST_BYTE;
      len_ctrl_ff <= pfr_pkg::RST_BYTE;
      max_len_ff <= pfr_pkg::RST_BYTE;
      rx_en_ff <= 1'b0;
      stream_ff <= 1'b0;
    end else if (wr) begin
      case (idx)
        pfr_pkg::IDX_SYNC_CTRL: sync_ctrl_ff <= pwdata[7:0];
        pfr_pkg::IDX_SYNC_UPPER: pat_ff[23:16] <= pwdata[7:0];
        pfr_pkg::IDX_SYNC_MIDDLE: pat_ff[15:8] <= pwdata[7:0];
        pfr_pkg::IDX_SYNC_LOWER: pat_ff[7:0] <= pwdata[7:0];
        pfr_pkg::IDX_TX_BASE: tx_base_ff <= pwdata[7:0];
        pfr_pkg::IDX_RX_BASE: rx_base_ff <= pwdata[7:0];
        pfr_pkg::IDX_LEN_CTRL: len_ctrl_ff <= pwdata[7:0];
        pfr_pkg::IDX_MAX_LEN: max_len_ff <= pwdata[7:0];
        pfr_pkg::IDX_CMD: begin
          rx_en_ff <= pwdata[pfr_pkg::CMD_RX_EN];
          stream_ff <= pwdata[pfr_pkg::CMD_STREAM];
        end
        default: ;
      endcase
    end
  end

  // packet RAM: no reset, contents are undefined until written
  wire ram_we = eng_we | (wr & ram_hit);
  wire [7:0] ram_wa = eng_we ? rx_ptr_ff : idx[7:0];
  wire [7:0] ram_wd = eng_we ? put_order(msb_first, nxt_rx_byte) : pwdata[7:0];
  always_ff @(posedge mclk) begin
    if (ram_we) begin
      pkt_ram[ram_wa] <= ram_wd;
    end
  end

  // ---------------- pins and bit clock ----------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_meta_ff <= 1'b0;
      rx_sync_ff <= 1'b0;
      stx_meta_ff <= 1'b0;
      stx_sync_ff <= 1'b0;
      tick_cnt_ff <= 7'h00;
      tick_ff <= 1'b0;
    end else begin
      rx_meta_ff <= rx_data_pin;
      rx_sync_ff <= rx_meta_ff;
      stx_meta_ff <= sport_tx_data;
      stx_sync_ff <= stx_meta_ff;
      tick_cnt_ff <= (tick_cnt_ff == pfr_pkg::BIT_LAST) ? 7'h00 : tick_cnt_ff + 7'h01;
      tick_ff <= tick_cnt_ff == pfr_pkg::BIT_LAST;
    end
  end

  // ---------------- transmitter ----------------
  wire [7:0] tx_len_field = pkt_ram[tx_base_ff];
  wire [7:0] tx_len = fixed_length_select ? max_len_ff : tx_len_field + len_off - pfr_pkg::LEN_BIAS;
  wire [1:0] sync_idx0 = (sync_len > pfr_pkg::SYNC_LEN_FULL) ? 2'h0 :
                         ((sync_len >= pfr_pkg::SYNC_LEN_MID) ? 2'h1 : 2'h2);
  wire sync_none = sync_len == 5'h00;
  wire tx_step = tick_ff & ~tx_idle & (tx_st_ff != pfr_pkg::TX_STREAM);
  wire tx_last = tx_step & (tx_bit_ff == 4'h0);
  wire [7:0] tx_ptr_inc = tx_ptr_ff + 8'h01;

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_ptr = tx_ptr_ff;
    nxt_tx_sidx = tx_sidx_ff;
    go_pay = 1'b0;
    case (tx_st_ff)
      pfr_pkg::TX_IDLE: begin
        if (tx_start) begin
          nxt_tx_st = pfr_pkg::TX_PRE;
          nxt_tx_sh = {pfr_pkg::PREAMBLE_PATTERN, 8'h00};
          nxt_tx_bit = 4'h7;
          nxt_tx_cnt = pfr_pkg::PREAMBLE_BYTES - 8'h01;
        end
      end
      pfr_pkg::TX_STREAM: begin
        if (!stream_ff) nxt_tx_st = pfr_pkg::TX_IDLE;
      end
      default: begin
        if (tx_step) begin
          nxt_tx_sh = {tx_sh_ff[14:0], 1'b0};
          nxt_tx_bit = tx_bit_ff - 4'h1;
        end
        if (tx_last) begin
          nxt_tx_bit = 4'h7;
          case (tx_st_ff)
            pfr_pkg::TX_PRE: begin
              if (tx_cnt_ff != 8'h00) begin
                nxt_tx_cnt = tx_cnt_ff - 8'h01;
                nxt_tx_sh = {pfr_pkg::PREAMBLE_PATTERN, 8'h00};
              end else if (sync_none) begin
                go_pay = 1'b1;
              end else begin
                nxt_tx_st = pfr_pkg::TX_SYNC;
                nxt_tx_sidx = sync_idx0;
                nxt_tx_sh = {pat_byte(pat_ff, sync_idx0), 8'h00};
              end
            end
            pfr_pkg::TX_SYNC: begin
              if (tx_sidx_ff == 2'h2) begin
                go_pay = 1'b1;
              end else begin
                nxt_tx_sidx = tx_sidx_ff + 2'h1;
                nxt_tx_sh = {pat_byte(pat_ff, tx_sidx_ff + 2'h1), 8'h00};
              end
            end
            pfr_pkg::TX_PAY: begin
              if (tx_cnt_ff != 8'h00) begin
                nxt_tx_cnt = tx_cnt_ff - 8'h01;
                nxt_tx_ptr = tx_ptr_inc;
                nxt_tx_sh = {put_order(msb_first, pkt_ram[tx_ptr_inc]), 8'h00};
              end else if (crc_on) begin
                nxt_tx_st = pfr_pkg::TX_CRC;
                nxt_tx_sh = crc_nxt;
                nxt_tx_bit = 4'hF;
              end else begin
                nxt_tx_st = pfr_pkg::TX_IDLE;
              end
            end
            default: nxt_tx_st = pfr_pkg::TX_IDLE;
          endcase
        end
      end
    endcase
    if (go_pay) begin
      nxt_tx_ptr = tx_base_ff;
      nxt_tx_cnt = tx_len - 8'h01;
      if (mode != pfr_pkg::MODE_PACKET) begin
        nxt_tx_st = pfr_pkg::TX_STREAM;
      end else if (tx_len == 8'h00) begin
        nxt_tx_st = crc_on ? pfr_pkg::TX_CRC : pfr_pkg::TX_IDLE;
        nxt_tx_sh = pfr_pkg::CRC_INIT;
        nxt_tx_bit = 4'hF;
      end else begin
        nxt_tx_st = pfr_pkg::TX_PAY;
        nxt_tx_sh = {put_order(msb_first, tx_len_field), 8'h00};
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_st_ff <= pfr_pkg::TX_IDLE;
      tx_sh_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_cnt_ff <= 8'h00;
      tx_ptr_ff <= 8'h00;
      tx_sidx_ff <= 2'h0;
      tx_data_ff <= 1'b0;
      tx_active_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_bit_ff <= nxt_tx_bit;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_ptr_ff <= nxt_tx_ptr;
      tx_sidx_ff <= nxt_tx_sidx;
      tx_data_ff <= (nxt_tx_st == pfr_pkg::TX_STREAM) ? stx_sync_ff : (nxt_tx_st != pfr_pkg::TX_IDLE) & nxt_tx_sh[15];
      tx_active_ff <= nxt_tx_st != pfr_pkg::TX_IDLE;
    end
  end
  assign tx_data = tx_data_ff;
  assign tx_active = tx_active_ff;

  // ---------------- receiver ----------------
  wire rx_bit = rx_sync_ff;
  wire rx_step = tick_ff & rx_en_ff;
  wire [23:0] rx_sh_new = {rx_sh_ff[22:0], rx_bit};
  wire alt = rx_bit != rx_sh_ff[0];
  wire pre_hit = alt & (pre_cnt_ff >= pfr_pkg::PRE_DETECT_BITS - 5'h01);
  wire [4:0] len_c = (sync_len > pfr_pkg::SYNC_LEN_MAX) ? pfr_pkg::SYNC_LEN_MAX : sync_len;
  wire [23:0] sync_mask = 24'hFFFFFF >> (pfr_pkg::SYNC_LEN_MAX - len_c);
  wire sync_hit = ((rx_sh_new ^ pat_ff) & sync_mask) == 24'h000000;
  wire [7:0] rx_len_field = put_order(msb_first, {rx_byte_ff[6:0], rx_bit});
  wire [7:0] rx_len = fixed_length_select ? max_len_ff : rx_len_field + len_off - pfr_pkg::LEN_BIAS;
  wire rx_len_bad = ~fixed_length_select & (rx_len > max_len_ff);

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_byte = rx_byte_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_ptr = rx_ptr_ff;
    {rx_fin, eng_we, rx_crc_clr, ev_done, ev_crc_err, ev_len_err, ev_irq, ev_len} = 8'h00;
    if (!rx_en_ff) begin
      nxt_rx_st = pfr_pkg::RX_OFF;
    end else begin
      case (rx_st_ff)
        pfr_pkg::RX_OFF: nxt_rx_st = pfr_pkg::RX_HUNT;
        pfr_pkg::RX_HUNT: begin
          if (rx_step & pre_hit) begin
            ev_irq = mode == pfr_pkg::MODE_SPORT_PRE;
            nxt_rx_st = (mode == pfr_pkg::MODE_PACKET) ? pfr_pkg::RX_SYNC : pfr_pkg::RX_SPORT;
          end
        end
        pfr_pkg::RX_SYNC: begin
          if (rx_step & sync_hit) begin
            nxt_rx_st = pfr_pkg::RX_LEN;
            nxt_rx_bit = 4'h7;
            nxt_rx_ptr = rx_base_ff;
            rx_crc_clr = 1'b1;
          end
        end
        pfr_pkg::RX_SPORT: ev_irq = rx_step & sync_hit & (mode == pfr_pkg::MODE_SPORT_SYNC);
        pfr_pkg::RX_CRC: begin
          if (rx_step) begin
            nxt_rx_bit = rx_bit_ff - 4'h1;
            if (rx_bit_ff == 4'h0) begin
              nxt_rx_st = pfr_pkg::RX_HUNT;
              ev_done = crc_nxt == 16'h0000;
              ev_crc_err = crc_nxt != 16'h0000;
            end
          end
        end
        default: begin
          if (rx_step) begin
            nxt_rx_byte = {rx_byte_ff[6:0], rx_bit};
            nxt_rx_bit = rx_bit_ff - 4'h1;
            if (rx_bit_ff == 4'h0) begin
              eng_we = 1'b1;
              nxt_rx_ptr = rx_ptr_ff + 8'h01;
              nxt_rx_bit = 4'h7;
              nxt_rx_cnt = rx_cnt_ff - 8'h01;
              if (rx_st_ff == pfr_pkg::RX_LEN) begin
                ev_len = 1'b1;
                nxt_rx_cnt = rx_len - 8'h01;
                nxt_rx_st = pfr_pkg::RX_PAY;
                if (rx_len_bad) begin
                  ev_len_err = 1'b1;
                  nxt_rx_st = pfr_pkg::RX_HUNT;
                end else if (rx_len <= 8'h01) begin
                  rx_fin = 1'b1;
                end
              end else if (rx_cnt_ff == 8'h01) begin
                rx_fin = 1'b1;
              end
            end
          end
        end
      endcase
      if (rx_fin) begin
        nxt_rx_st = crc_on ? pfr_pkg::RX_CRC : pfr_pkg::RX_HUNT;
        nxt_rx_bit = 4'hF;
        ev_done = ~crc_on;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_st_ff <= pfr_pkg::RX_OFF;
      rx_byte_ff <= 8'h00;
      rx_bit_ff <= 4'h0;
      rx_cnt_ff <= 8'h00;
      rx_ptr_ff <= 8'h00;
      rx_sh_ff <= 24'h000000;
      pre_cnt_ff <= 5'h00;
      rx_count_ff <= 8'h00;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_byte_ff <= nxt_rx_byte;
      rx_bit_ff <= nxt_rx_bit;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_ptr_ff <= nxt_rx_ptr;
      if (rx_step) begin
        rx_sh_ff <= rx_sh_new;
        pre_cnt_ff <= !alt ? 5'h00 : (pre_hit ? pre_cnt_ff : pre_cnt_ff + 5'h01);
      end
      if (ev_len) rx_count_ff <= rx_len;
    end
  end

  // sticky flags: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      done_ff <= 1'b0;
      crc_err_ff <= 1'b0;
      len_err_ff <= 1'b0;
      irq_ff <= 1'b0;
      sport_data_ff <= 1'b0;
      sport_valid_ff <= 1'b0;
    end else begin
      done_ff <= ev_done | (done_ff & ~(st_clr & pwdata[pfr_pkg::ST_RX_DONE]));
      crc_err_ff <= ev_crc_err | (crc_err_ff & ~(st_clr & pwdata[pfr_pkg::ST_CRC_ERR]));
      len_err_ff <= ev_len_err | (len_err_ff & ~(st_clr & pwdata[pfr_pkg::ST_LEN_ERR]));
      irq_ff <= rx_en_ff & (ev_irq | (irq_ff & ~(st_clr & pwdata[pfr_pkg::ST_IRQ])));
      sport_valid_ff <= rx_step & (rx_st_ff == pfr_pkg::RX_SPORT);
      if (rx_step) sport_data_ff <= rx_bit;
    end
  end
  assign sport_rx_data = sport_data_ff;
  assign sport_rx_valid = sport_valid_ff;
  assign general_purpose_interrupt_pin = irq_ff;

  // transmit has the shared CRC when both directions run at once
  wire tx_crc_use = tx_step & (tx_st_ff == pfr_pkg::TX_PAY);
  wire rx_crc_use = rx_step & ((rx_st_ff == pfr_pkg::RX_LEN) | (rx_st_ff == pfr_pkg::RX_PAY) |
                               (rx_st_ff == pfr_pkg::RX_CRC));

  pfr_crc u_crc (
    .mclk(mclk),
    .nrst(nrst),
    .clr(go_pay | rx_crc_clr),
    .en(tx_crc_use | rx_crc_use),
    .din(tx_crc_use ? tx_sh_ff[15] : rx_bit),
    .crc_nxt(crc_nxt)
  );
endmodule

// ==== bench/pfr_monitor.sv ====
// assertions on the framer APB and serial pins
// assumes a bind onto pfr_framer, package compiled first
module pfr_monitor (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pfr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_data,
  input wire logic tx_active,
  input wire logic sport_rx_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire [9:0] idx = paddr[11:2];
  wire acc = psel && penable;
  wire in_cfg = idx >= pfr_pkg::IDX_SYNC_CTRL && idx <= pfr_pkg::IDX_MAX_LEN;
  wire mapped = idx < 10'h100 || in_cfg || (idx >= pfr_pkg::IDX_CMD && idx <= pfr_pkg::IDX_RX_COUNT);
  logic last_ff;
  logic act_ff;
  logic seen_ff;
  logic [15:0] gap_ff;
  // first bit of a frame is shortened, so spacing counts from the second change
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      last_ff <= 1'b0;
      act_ff <= 1'b0;
      seen_ff <= 1'b0;
      gap_ff <= 16'h0000;
    end else begin
      last_ff <= tx_data;
      act_ff <= tx_active;
      seen_ff <= tx_active && (seen_ff || (act_ff && tx_data != last_ff));
      gap_ff <= (tx_data != last_ff) ? 16'h0000 : gap_ff + 16'h0001;
    end
  end
  sequence s_start;
    acc && pready && pwrite && idx == pfr_pkg::IDX_CMD && pwdata[0] && !tx_active;
  endsequence
  sequence s_read;
    acc && !pwrite;
  endsequence
  a_map_slverr: assert property (acc |-> pslverr == !mapped) else $error("slave error off map");
  a_bad_read: assert property (s_read ##0 !mapped |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_read_upper: assert property (s_read |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
  a_ready_wait: assert property (!pready |=> pready) else $error("ready low too long");
  a_tx_start: assert property (s_start |=> tx_active) else $error("transmit did not start");
  a_first_bit: assert property ($rose(tx_active) |-> tx_data) else $error("frame not led by a one");
  a_frame_min: assert property ($rose(tx_active) |=> tx_active [*8]) else $error("frame too short");
  a_bit_spacing: assert property (tx_active && seen_ff && tx_data != last_ff |-> gap_ff % 16'h0064 == 16'h0063)
    else $error("bit time wrong");
  a_rx_pulse: assert property (sport_rx_valid |=> !sport_rx_valid [*8]) else $error("rx valid not a pulse");
endmodule
bind pfr_framer pfr_monitor u_mon (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .tx_data, .tx_active, .sport_rx_valid);

// ==== bench/pfr_radio.sv ====
// remote radio: records each sent frame and replays it to the receiver
// assumes 100 mclk cycles per bit; idle line toggles as it has no pull
module pfr_radio (
  input wire logic mclk,
  input wire logic tx_data,
  input wire logic tx_active,
  input wire logic replay,
  input wire logic corrupt,
  output logic rx_line,
  output logic busy,
  output logic [255:0] cap,
  output int cap_n
);
  timeunit 1ns;
  timeprecision 1ns;
  int run = 0;
  int pos = 0;
  int tk = 0;
  logic last = 0;
  initial begin
    rx_line = 0;
    busy = 0;
    cap = '0;
    cap_n = 0;
  end
  // a run of equal bits is rounded up, the first bit being short
  always @(posedge mclk) begin
    if (tx_active && run == 0) begin
      cap = '0;
      cap_n = 0;
    end
    if (tx_active && (tx_data == last || run == 0)) run++;
    else if (run > 0) begin
      for (int i = 0; i < (run + 99) / 100; i++) begin
        cap = {cap[254:0], last};
        cap_n++;
      end
      run = tx_active;
    end
    last = tx_data;
  end
  always @(posedge mclk) begin
    if (replay && !busy) begin
      busy <= 1;
      pos = cap_n;
      tk = 0;
    end else if (busy) begin
      if (tk == 0 && pos == 0) busy <= 0;
      else if (tk == 0) begin
        pos--;
        rx_line <= cap[pos] ^ (corrupt && pos == 0);
      end
      tk = (tk + 1) % 100;
    end
    if (!busy) rx_line <= !rx_line;
  end
endmodule

// ==== bench/sync_and_packet_length_framing_bench.sv ====
// framer bench: APB tasks, loop-back radio, register, framing and receive tests
// assumes package, design, monitor and radio model compiled first
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module sync_and_packet_length_framing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, replay = 0, corrupt = 0, err, mid, seen_v = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rx_pin, tx_data, tx_active, srx_v, srx_d, gpi, busy;
  logic [255:0] cap, exp;
  logic [23:0] sdat = 24'h000000, snap = 24'h000000;
  int cap_n, miscompares = 0, num_checks = 0, cyc = 0;
  logic [7:0] lens [4] = '{8'h00, 8'h05, 8'h0C, 8'h18};
  logic [7:0] pay [3] = '{8'h05, 8'h3C, 8'h7E};
  pfr_framer u_dut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_data_pin(rx_pin), .sport_tx_data(1'b0), .tx_data, .tx_active, .sport_rx_data(srx_d), .sport_rx_valid(srx_v),
    .general_purpose_interrupt_pin(gpi));
  pfr_radio u_radio (.mclk, .tx_data, .tx_active, .replay, .corrupt, .rx_line(rx_pin), .busy, .cap, .cap_n);
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (srx_v) begin
      sdat = {sdat[22:0], srx_d};
      // the first valid bit with the interrupt up closes the sync word in mode 2
      if (gpi && snap == 24'h000000) snap = sdat;
      seen_v = 1;
    end
    if (cyc == 99000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (!pready) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic send();
    apb(1, pfr_pkg::IDX_CMD, 8'h01);
    repeat (2) @(posedge mclk);
    while (tx_active) @(posedge mclk);
    @(posedge mclk);
  endtask
  task automatic play(input logic c);
    corrupt <= c;
    replay <= 1;
    @(posedge mclk);
    replay <= 0;
    // 35 bits in: past preamble detection, before the sync word ends
    repeat (3500) @(posedge mclk);
    mid = gpi;
    while (busy) @(posedge mclk);
    repeat (10) @(posedge mclk);
    apb(0, pfr_pkg::IDX_STATUS, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1;
    for (int i = 0; i < 8; i++) begin
      apb(0, 10'h120 + i[9:0], 8'h00);
      `CHK("reset", (i == 0) ? 32'h18 : 32'h0, rd)
      apb(1, 10'h120 + i[9:0], 8'h5A + i[7:0]);
      apb(0, 10'h120 + i[9:0], 8'h00);
      `CHK("rw", {24'h0, 8'h5A + i[7:0]}, rd)
    end
    apb(1, 10'h128, 8'hFF);
    `CHK("slverr", 1'b1, err)
    apb(0, 10'h128, 8'h00);
    `CHK("unmapped", 32'h0, rd)
    $display("register test done");
    apb(1, pfr_pkg::IDX_SYNC_UPPER, 8'hA1);
    apb(1, pfr_pkg::IDX_SYNC_MIDDLE, 8'hB2);
    apb(1, pfr_pkg::IDX_SYNC_LOWER, 8'hAB);
    apb(1, pfr_pkg::IDX_TX_BASE, 8'h10);
    apb(1, 10'h010, 8'h96);
    apb(1, pfr_pkg::IDX_LEN_CTRL, 8'hC0);
    apb(1, pfr_pkg::IDX_MAX_LEN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      apb(1, pfr_pkg::IDX_SYNC_CTRL, lens[k]);
      send();
      exp = {232'h0, 24'hAAAAAA};
      if (k == 3) exp = {exp[247:0], 8'hA1};
      if (k >= 2) exp = {exp[247:0], 8'hB2};
      if (k >= 1) exp = {exp[247:0], 8'hAB};
      exp = {exp[247:0], 8'h96};
      `CHK("tx bits", exp, cap)
      `CHK("tx count", 32 + 8 * k, cap_n)
    end
    apb(1, pfr_pkg::IDX_LEN_CTRL, 8'h40);
    send();
    `CHK("lsb first", {24'hAAAAAA, 24'hA1B2AB, 8'h69}, cap)
    $display("sync length test done");
    for (int i = 0; i < 3; i++) apb(1, 10'h010 + i[9:0], pay[i]);
    apb(1, pfr_pkg::IDX_LEN_CTRL, 8'hA2);
    apb(1, pfr_pkg::IDX_MAX_LEN, 8'h10);
    apb(1, pfr_pkg::IDX_RX_BASE, 8'h40);
    send();
    `CHK("tx crc count", 88, cap_n)
    apb(1, pfr_pkg::IDX_CMD, 8'h02);
    play(0);
    `CHK("rx done", 3'h1, rd[4:2])
    apb(0, pfr_pkg::IDX_RX_COUNT, 8'h00);
    `CHK("rx count", 32'h3, rd)
    for (int i = 0; i < 3; i++) begin
      apb(0, 10'h040 + i[9:0], 8'h00);
      `CHK("rx byte", {24'h0, pay[i]}, rd)
    end
    apb(1, pfr_pkg::IDX_STATUS, 8'h3C);
    play(1);
    `CHK("crc err", 3'h2, rd[4:2])
    apb(1, pfr_pkg::IDX_STATUS, 8'h3C);
    apb(1, pfr_pkg::IDX_MAX_LEN, 8'h02);
    play(0);
    `CHK("len err", 1'b1, rd[4])
    $display("receive test done");
    apb(1, pfr_pkg::IDX_MAX_LEN, 8'h10);
    for (int m = 1; m < 3; m++) begin
      apb(1, pfr_pkg::IDX_LEN_CTRL, {3'h5, m[1:0], 3'h2});
      apb(1, pfr_pkg::IDX_CMD, 8'h00);
      apb(1, pfr_pkg::IDX_STATUS, 8'h3C);
      apb(1, pfr_pkg::IDX_CMD, 8'h02);
      seen_v = 0;
      snap = 24'h000000;
      play(0);
      `CHK("irq mid", m == 1, mid)
      `CHK("irq end", 1'b1, gpi)
      `CHK("rx stream", 1'b1, seen_v)
      if (m == 2) `CHK("rx sync data", 24'hA1B2AB, snap)
    end
    $display("serial mode test done");
    end_sim();
  end
endmodule
